// file: include/bwf_pkg.sv
package bwf_pkg;
   // Configuration and status bit positions
   localparam int unsigned CFG_ADDR = 16'h0800;
   localparam int unsigned STAT_ADDR = 16'h0820;
   localparam int unsigned CTRL_ADDR = 16'h0840;
   localparam int unsigned CFG_TEST_MAP_BIT = 0;
   localparam int unsigned CFG_SLEEP_WAKE_ERROR_DISABLE_BIT = 1;
   localparam int unsigned CFG_FAILSAFE_BIT = 13;
   localparam int unsigned CFG_TEST_EN_BIT = 21;
   localparam int unsigned STAT_SLEEP_FAULT_BIT = 23;
   localparam int unsigned STAT_POWER_ON_BIT = 0;
   localparam int unsigned STAT_LOCAL_WAKE_BIT = 1;
   localparam int unsigned STAT_BUS_WAKE_BIT = 2;
   localparam int unsigned STAT_MODE_LSB = 4;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_CLR_FLAGS_BIT = 4;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // Timing, clock 20 MHz
   localparam int unsigned CLOCK_HZ = 20_000_000;
   localparam int unsigned WAKE_FILTER_NS = 1000;
   localparam int unsigned WAKE_FILTER_CYCLES = (WAKE_FILTER_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned LOCAL_WAKE_FILTER_NS = 50000;
   localparam int unsigned LOCAL_WAKE_FILTER_CYCLES =
      (LOCAL_WAKE_FILTER_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned WAKE_TIMEOUT_US = 1800;
   localparam int unsigned WAKE_TIMEOUT_CYCLES = WAKE_TIMEOUT_US * (CLOCK_HZ / 1_000_000);
   localparam int unsigned INACTIVITY_S = 240;
   localparam longint unsigned INACTIVITY_CYCLES = 64'(INACTIVITY_S) * 64'(CLOCK_HZ);
   localparam int unsigned SILENCE_US = 900;
   localparam int unsigned SILENCE_CYCLES = SILENCE_US * (CLOCK_HZ / 1_000_000);
   // Operating modes, one-hot
   typedef enum logic [2:0] {
      MODE_SLEEP = 3'b001,
      MODE_STANDBY = 3'b010,
      MODE_NORMAL = 3'b100
   } bwf_mode_type;
   // Wake-up pattern detector states, one-hot
   typedef enum logic [4:0] {
      WP_IDLE = 5'b00001,
      WP_DOM1 = 5'b00010,
      WP_REC = 5'b00100,
      WP_DOM2 = 5'b01000,
      WP_REQ = 5'b10000
   } bwf_wup_type;
endpackage

// file: hdl/bwf_filter.sv
module bwf_filter #(
   parameter int unsigned CYCLES = 20,
   parameter int unsigned WIDTH = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic din,
   output logic stable_q,
   output logic change_q
);
   import bwf_pkg::*;
   logic [WIDTH-1:0] count_q;
   logic cand_q;
   wire differs = din != stable_q;
   wire done = count_q >= WIDTH'(CYCLES - 1);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         cand_q <= 1'b0;
         stable_q <= 1'b1;
         change_q <= 1'b0;
      end else begin
         change_q <= 1'b0;
         if (!differs || din != cand_q) begin
            count_q <= '0;
            cand_q <= din;
         end else if (done) begin
            stable_q <= din;
            change_q <= 1'b1;
            count_q <= '0;
         end else begin
            count_q <= count_q + WIDTH'(1);
         end
      end
   end
endmodule // bwf_filter

// file: hdl/bwf_wake_failsafe.sv
// Behaviour
// R1: Pattern: dominant, recessive, dominant, each filtered
// R2: Pattern wakes to standby, asserts both pins
// R3: Falling internal receive in sleep wakes device
// R4: After pattern, mirror filtered dominants low
// R5: Unfiltered activity never resets pattern detector
// R6: Short states ignored, long states counted
// R7: Normal mode or undervoltage drops request
// R8: Timeout returns detector to idle, waiting dominant
// R9: Local wake on either edge
// R10: Local wake only in sleep/standby, to standby
// R11: Local wake needs minimum stable level
// R12: Power-up may flag a local wake
// R13: Config bit 21 enables test remapping
// R14: Config bit 0 selects remapping set
// R15: Test mode routes transceiver enable to interrupt
// R16: Bit 1 disables error timer, reset re-enables
// R17: Failsafe off until config bit 13 set
// R18: Power-on flag uncleared in time forces sleep
// R19: Wake starts silence, inactivity timers; expiry sleeps
// R20: Failsafe: unserviced wake in time forces sleep
// R21: Bus silence for inactivity time forces sleep
// R22: Standby reports only the first wake interrupt
// R23: Fault-caused sleep sets sleep status flag
// R24: All durations are parameterised cycle counts
module bwf_wake_failsafe #(
   parameter longint unsigned INACTIVITY_COUNT = bwf_pkg::INACTIVITY_CYCLES,
   parameter int unsigned SILENCE_COUNT = bwf_pkg::SILENCE_CYCLES,
   parameter int unsigned WAKE_TIMEOUT_COUNT = bwf_pkg::WAKE_TIMEOUT_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata_q,
   input wire logic bus_dominant,
   input wire logic wake_pin,
   input wire logic supply_undervoltage,
   input wire logic controller_interrupt_wake,
   input wire logic controller_transmit,
   input wire logic transceiver_receive_output,
   input wire logic transceiver_enable,
   input wire logic core_interrupt_n,
   input wire logic general_io_pin_one_in,
   output logic general_io_pin_one_out_q,
   output logic general_io_pin_one_oe_q,
   output logic general_output_pin_two_q,
   output logic interrupt_out_n_q,
   output logic wake_request_out_n_q,
   output logic internal_receive_q,
   output logic transceiver_transmit_input_q,
   output logic core_receive_q,
   output logic [2:0] mode_q
);
   import bwf_pkg::*;

   // Input synchronisers
   logic [1:0] bus_sync_q, wake_sync_q, uv_sync_q, gpio_sync_q;
   logic bus_dom, uv, gpio_in;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_sync_q <= 2'b00;
         wake_sync_q <= 2'b11;
         uv_sync_q <= 2'b00;
         gpio_sync_q <= 2'b11;
      end else begin
         bus_sync_q <= {bus_sync_q[0], bus_dominant};
         wake_sync_q <= {wake_sync_q[0], wake_pin};
         uv_sync_q <= {uv_sync_q[0], supply_undervoltage};
         gpio_sync_q <= {gpio_sync_q[0], general_io_pin_one_in};
      end
   end
   assign bus_dom = bus_sync_q[1];
   assign uv = uv_sync_q[1];
   assign gpio_in = gpio_sync_q[1];

   // Filters: bus state and wake pin level
   logic bus_filt, bus_change, wake_filt, wake_change;
   bwf_filter #(.CYCLES(WAKE_FILTER_CYCLES), .WIDTH(16)) u_bus_filter ( // [R6] [R24]
      .clock(clock),
      .rst_n(rst_n),
      .din(!bus_dom),
      .stable_q(bus_filt),
      .change_q(bus_change)
   );
   bwf_filter #(.CYCLES(LOCAL_WAKE_FILTER_CYCLES), .WIDTH(16)) u_wake_filter ( // [R11]
      .clock(clock),
      .rst_n(rst_n),
      .din(wake_sync_q[1]),
      .stable_q(wake_filt),
      .change_q(wake_change)
   );
   wire filt_dom_start = bus_change && !bus_filt;
   wire filt_rec_start = bus_change && bus_filt;
   wire filt_dominant = !bus_filt;

   // Register bus decode
   logic [31:0] cfg_q;
   logic ci_flag_q;
   wire wr_cfg = reg_write && reg_addr == 16'(CFG_ADDR);
   wire wr_ctrl = reg_write && reg_addr == 16'(CTRL_ADDR);
   wire clr_flags = wr_ctrl && reg_wdata[CTRL_CLR_FLAGS_BIT];
   wire cmd_valid = wr_ctrl && reg_wdata[CTRL_MODE_LSB +: 3] != 3'b000;
   wire [2:0] cmd_mode = reg_wdata[CTRL_MODE_LSB +: 3];
   wire test_en = cfg_q[CFG_TEST_EN_BIT]; // [R13]
   wire test_core = cfg_q[CFG_TEST_MAP_BIT]; // [R14]
   wire swe_en = !cfg_q[CFG_SLEEP_WAKE_ERROR_DISABLE_BIT]; // [R16]
   wire failsafe_en = cfg_q[CFG_FAILSAFE_BIT]; // [R17]

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RESET; // [R16] [R17]
      end else if (wr_cfg) begin
         cfg_q <= reg_wdata;
      end
   end

   // Wake-up pattern detector
   bwf_wup_type wup_q, wup_d;
   logic [31:0] wto_q;
   bwf_mode_type mode_s;
   wire in_sleep = mode_s == MODE_SLEEP;
   wire to_normal = cmd_valid && cmd_mode == 3'(MODE_NORMAL);
   wire wup_timeout = wto_q >= WAKE_TIMEOUT_COUNT - 1;
   always_comb begin
      wup_d = wup_q;
      case (wup_q)
         WP_IDLE: if (filt_dom_start) wup_d = WP_DOM1; // [R1]
         WP_DOM1: if (wup_timeout) wup_d = WP_IDLE; // [R8]
            else if (filt_rec_start) wup_d = WP_REC; // [R5]
         WP_REC: if (wup_timeout) wup_d = WP_IDLE; // [R8]
            else if (filt_dom_start) wup_d = WP_REQ; // [R1] [R5]
         WP_DOM2: wup_d = WP_REQ;
         WP_REQ: wup_d = WP_REQ;
         default: wup_d = WP_IDLE;
      endcase
      if (to_normal || uv || !(in_sleep || wup_q == WP_REQ)) wup_d = WP_IDLE; // [R7]
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wup_q <= WP_IDLE;
         wto_q <= '0;
      end else begin
         wup_q <= wup_d;
         wto_q <= (wup_d == WP_DOM1 || wup_d == WP_REC) && wup_d != WP_IDLE
            && (wup_q != WP_IDLE) ? wto_q + 32'd1 : '0; // [R8]
      end
   end
   wire bus_request_low = wup_q == WP_REQ && filt_dominant; // [R4]
   wire pattern_done = wup_q == WP_REC && wup_d == WP_REQ; // [R2]

   // Falling edge on internal receive path
   logic rx_prev_q;
   wire rx_int_d = !(bus_request_low || pattern_done);
   wire rx_fall = rx_prev_q && !rx_int_d; // [R3]

   // Local wake
   logic lw_seen_q;
   wire local_wake = wake_change && mode_s != MODE_NORMAL; // [R9] [R10]

   // Mode control and timers
   logic [63:0] inact_q;
   logic [31:0] sil_q;
   logic sleep_fault_q, power_on_q, lw_flag_q, bw_flag_q, reported_q, timer_run_q;
   logic fs_run_q;
   wire wake_event = in_sleep && (rx_fall || local_wake || controller_interrupt_wake);
   wire inact_exp = inact_q >= INACTIVITY_COUNT - 1;
   wire sil_exp = sil_q >= SILENCE_COUNT - 1;
   wire silent_flag = sil_exp;
   wire pwr_timeout = power_on_q && inact_exp; // [R18]
   wire swe_timeout = timer_run_q && swe_en && inact_exp; // [R19]
   wire fs_timeout = fs_run_q && failsafe_en && inact_exp; // [R20]
   wire fault_sleep = !in_sleep && (pwr_timeout || swe_timeout || fs_timeout);
   wire silence_sleep = !in_sleep && silent_flag && failsafe_en && inact_exp; // [R21]
   wire any_fault = fault_sleep || silence_sleep;
   bwf_mode_type mode_d;
   always_comb begin
      mode_d = mode_s;
      if (any_fault) mode_d = MODE_SLEEP; // [R18] [R21]
      else if (wake_event) mode_d = MODE_STANDBY; // [R2] [R3] [R10]
      else if (cmd_valid && !in_sleep) begin
         case (cmd_mode)
            3'(MODE_SLEEP): mode_d = MODE_SLEEP;
            3'(MODE_STANDBY): mode_d = MODE_STANDBY;
            3'(MODE_NORMAL): mode_d = MODE_NORMAL;
            default: mode_d = mode_s;
         endcase
      end
   end
   wire mode_change = mode_d != mode_s;
   wire host_served = clr_flags || to_normal;
   wire silent_reset = !filt_dominant && !bus_change;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_s <= MODE_STANDBY;
         inact_q <= '0;
         sil_q <= '0;
         power_on_q <= 1'b1;
         timer_run_q <= 1'b0;
         fs_run_q <= 1'b0;
         sleep_fault_q <= 1'b0;
         lw_flag_q <= 1'b0;
         bw_flag_q <= 1'b0;
         reported_q <= 1'b0;
         rx_prev_q <= 1'b1;
         lw_seen_q <= 1'b0;
      end else begin
         mode_s <= mode_d;
         rx_prev_q <= rx_int_d;
         lw_seen_q <= lw_seen_q || local_wake;
         // One shared counter: reset on mode change, host service or in sleep [R19] [R24]
         if (mode_change || host_served || in_sleep) inact_q <= '0;
         else inact_q <= inact_q + 64'd1;
         if (bus_change || in_sleep) sil_q <= '0; // [R19]
         else if (!sil_exp) sil_q <= sil_q + 32'd1;
         if (host_served) power_on_q <= 1'b0; // [R18]
         if (wake_event) begin
            timer_run_q <= 1'b1; // [R19]
            fs_run_q <= 1'b1; // [R20]
         end else if (host_served || mode_d == MODE_SLEEP) begin
            timer_run_q <= 1'b0;
            fs_run_q <= 1'b0;
         end
         if (any_fault) sleep_fault_q <= 1'b1; // [R23]
         else if (clr_flags) sleep_fault_q <= 1'b0;
         // Flags: set wins over clear; first wake only [R22]
         if (local_wake && !reported_q) lw_flag_q <= 1'b1; // [R9] [R12]
         else if (clr_flags) lw_flag_q <= 1'b0;
         if ((rx_fall && in_sleep) && !reported_q) bw_flag_q <= 1'b1;
         else if (clr_flags) bw_flag_q <= 1'b0;
         if (wake_event) reported_q <= 1'b1; // [R22]
         else if (mode_d != MODE_STANDBY) reported_q <= 1'b0;
      end
   end

   // Pin outputs and test-mode remapping
   wire wake_pending = lw_flag_q || bw_flag_q || ci_flag_q;
   wire int_d = test_en ? !transceiver_enable : !(wake_pending || power_on_q); // [R15] [R2]
   wire rx_out = rx_int_d && !(mode_s == MODE_NORMAL && !transceiver_receive_output);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_out_n_q <= 1'b1;
         wake_request_out_n_q <= 1'b1;
         internal_receive_q <= 1'b1;
         transceiver_transmit_input_q <= 1'b1;
         core_receive_q <= 1'b1;
         general_io_pin_one_out_q <= 1'b0;
         general_io_pin_one_oe_q <= 1'b0;
         general_output_pin_two_q <= 1'b1;
         mode_q <= 3'(MODE_STANDBY);
      end else begin
         interrupt_out_n_q <= int_d; // [R2] [R15]
         wake_request_out_n_q <= !(wake_pending || mode_s == MODE_STANDBY); // [R2]
         internal_receive_q <= rx_out; // [R4]
         mode_q <= mode_s;
         general_io_pin_one_out_q <= 1'b0;
         general_io_pin_one_oe_q <= 1'b0;
         if (test_en && !test_core) begin
            transceiver_transmit_input_q <= gpio_in; // [R14]
            core_receive_q <= 1'b1;
            general_output_pin_two_q <= transceiver_receive_output;
         end else if (test_en && test_core) begin
            transceiver_transmit_input_q <= 1'b1; // [R14]
            core_receive_q <= gpio_in;
            general_output_pin_two_q <= controller_transmit;
         end else begin
            transceiver_transmit_input_q <= controller_transmit; // [R13]
            core_receive_q <= rx_out;
            general_output_pin_two_q <= core_interrupt_n;
         end
      end
   end

   // Register read path
   wire [31:0] stat_word = (32'(sleep_fault_q) << STAT_SLEEP_FAULT_BIT)
      | (32'(power_on_q) << STAT_POWER_ON_BIT)
      | (32'(lw_flag_q) << STAT_LOCAL_WAKE_BIT)
      | (32'(bw_flag_q) << STAT_BUS_WAKE_BIT)
      | (32'(mode_s) << STAT_MODE_LSB);
   wire [31:0] rd_d = reg_addr == 16'(CFG_ADDR) ? cfg_q :
      reg_addr == 16'(STAT_ADDR) ? stat_word :
      reg_addr == 16'(CTRL_ADDR) ? 32'(mode_s) : 32'h0000_0000;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= reg_read ? rd_d : 32'h0000_0000;
      end
   end
   logic unused_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) unused_q <= 1'b0;
      else unused_q <= wake_filt ^ lw_seen_q ^ silent_reset;
   end
   // Controller interrupt wake flag, first wake only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ci_flag_q <= 1'b0;
      else if (controller_interrupt_wake && in_sleep && !reported_q) ci_flag_q <= 1'b1; // [R22]
      else if (clr_flags) ci_flag_q <= 1'b0;
   end
endmodule // bwf_wake_failsafe

// file: dv/bwf_props.sv
module bwf_props
   import bwf_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic controller_transmit,
   input wire logic transceiver_receive_output,
   input wire logic transceiver_enable,
   input wire logic core_interrupt_n,
   input wire logic general_io_pin_one_oe_q,
   input wire logic general_output_pin_two_q,
   input wire logic interrupt_out_n_q,
   input wire logic wake_request_out_n_q,
   input wire logic [2:0] mode_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] cfg_q;
   logic [1:0] up_q;
   // Shadow of the configuration word and a short count after reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RESET;
         up_q <= 2'h0;
      end else begin
         if (reg_write && reg_addr == 16'(CFG_ADDR)) begin
            cfg_q <= reg_wdata;
         end
         if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
         end
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_test_irq: assert property (
      $past(cfg_q[21]) |-> interrupt_out_n_q == !$past(transceiver_enable))
      else $error("interrupt pin does not follow transceiver enable");
   chk_map_rx: assert property (
      $past(cfg_q[21]) && !$past(cfg_q[0])
      |-> general_output_pin_two_q == $past(transceiver_receive_output))
      else $error("pin two not transceiver receive");
   chk_map_core: assert property (
      $past(cfg_q[21]) && $past(cfg_q[0])
      |-> general_output_pin_two_q == $past(controller_transmit))
      else $error("pin two not controller transmit");
   chk_map_off: assert property (
      up_q == 2'h3 && !$past(cfg_q[21])
      |-> general_output_pin_two_q == $past(core_interrupt_n))
      else $error("pin two remapped outside test mode");
   chk_gpio_input: assert property (general_io_pin_one_oe_q == 1'b0)
      else $error("io pin one driven");
   chk_mode_onehot: assert property ($onehot(mode_q))
      else $error("mode not one-hot");
   chk_sleep_exit: assert property (
      $past(mode_q) == MODE_SLEEP && mode_q != MODE_SLEEP |-> mode_q == MODE_STANDBY)
      else $error("sleep left to a mode other than standby");
   chk_wake_pins: assert property (
      $past(mode_q) == MODE_SLEEP && mode_q == MODE_STANDBY && !cfg_q[21]
      |-> ##[0:3] (!interrupt_out_n_q && !wake_request_out_n_q))
      else $error("wake not signalled on both pins");
   chk_wkrq_standby: assert property (
      up_q == 2'h3 && mode_q == MODE_STANDBY && $past(mode_q) == MODE_STANDBY
      |-> !wake_request_out_n_q)
      else $error("wake request pin high in standby");
   cov_wake: cover property ($past(mode_q) == MODE_SLEEP && mode_q == MODE_STANDBY);
   cov_test: cover property (cfg_q[21] && cfg_q[0]);
   cov_normal: cover property (mode_q == MODE_NORMAL);
endmodule // bwf_props

bind bwf_wake_failsafe bwf_props u_props (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .controller_transmit(controller_transmit),
   .transceiver_receive_output(transceiver_receive_output),
   .transceiver_enable(transceiver_enable), .core_interrupt_n(core_interrupt_n),
   .general_io_pin_one_oe_q(general_io_pin_one_oe_q),
   .general_output_pin_two_q(general_output_pin_two_q), .interrupt_out_n_q(interrupt_out_n_q),
   .wake_request_out_n_q(wake_request_out_n_q), .mode_q(mode_q));

// file: dv/bwf_bus_node.sv
module bwf_bus_node (
   input wire logic clock,
   output logic bus_dominant
);
   timeunit 1ns;
   timeprecision 1ns;
   initial bus_dominant = 1'b0;
   // Holds one bus level for a number of cycles, at least one
   task automatic hold(input logic level, input int unsigned cycles);
      @(posedge clock);
      bus_dominant <= level;
      repeat (cycles - 1) @(posedge clock);
   endtask
   // Dominant, recessive, dominant, then idle recessive
   task automatic pattern(input int unsigned len);
      hold(1'b1, len);
      hold(1'b0, len);
      hold(1'b1, len);
      hold(1'b0, len);
   endtask
endmodule // bwf_bus_node

// file: dv/test_bus_wake_and_failsafe_control.sv
module test_bus_wake_and_failsafe_control;
   import bwf_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst_n, reg_write, reg_read, wake_pin, ctx, trx, ten, cin_n, gin;
   logic uv, ciw, gout;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata_q, d, cfg;
   logic bus_dominant, irq_n, wkrq_n, rxi, txi, crx, pin2;
   logic [2:0] mode_q;
   int mismatches, checks_done;
   bwf_bus_node node (.clock(clock), .bus_dominant(bus_dominant));
   bwf_wake_failsafe #(.INACTIVITY_COUNT(200), .SILENCE_COUNT(50), .WAKE_TIMEOUT_COUNT(500))
   uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
      .bus_dominant(bus_dominant), .wake_pin(wake_pin), .supply_undervoltage(uv),
      .controller_interrupt_wake(ciw), .controller_transmit(ctx),
      .transceiver_receive_output(trx), .transceiver_enable(ten), .core_interrupt_n(cin_n),
      .general_io_pin_one_in(gin), .general_io_pin_one_out_q(gout), .general_io_pin_one_oe_q(),
      .general_output_pin_two_q(pin2), .interrupt_out_n_q(irq_n),
      .wake_request_out_n_q(wkrq_n), .internal_receive_q(rxi),
      .transceiver_transmit_input_q(txi), .core_receive_q(crx), .mode_q(mode_q));
   always #25 clock = ~clock;
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      v = reg_rdata_q;
   endtask
   task automatic wait_mode(input logic [2:0] m, input int limit);
      for (int n = 0; n < limit && mode_q !== m; n++) @(negedge clock);
      check("mode", 32'(m), 32'(mode_q));
   endtask
   function automatic logic [31:0] bit_of(input logic [31:0] v, input int unsigned b);
      return (v >> b) & 32'h1;
   endfunction
   function automatic logic exp_pin2(input logic [31:0] c);
      return c[21] ? (c[0] ? ctx : trx) : cin_n;
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clock);
      mismatches++;
      report_and_stop();
   end
   initial begin
      {clock, rst_n, reg_write, reg_read, wake_pin, ctx, trx, ten, cin_n, gin} = 10'h020;
      {uv, ciw} = 2'b00;
      reg_addr = 16'h0;
      reg_wdata = 32'h0;
      mismatches = 0;
      checks_done = 0;
      void'($urandom(32'hf8e7));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rd(16'(STAT_ADDR), d);
      check("power on flag", 32'h1, bit_of(d, STAT_POWER_ON_BIT));
      rd(16'(CFG_ADDR), d);
      check("config reset", CFG_RESET, d);
      rd(16'h0900, d);
      check("unmapped read", 32'h0, d);
      $display("reset test done");
      wait_mode(MODE_SLEEP, 250);
      repeat (4) node.pattern(3 + $urandom_range(9));
      @(negedge clock);
      check("mode", 32'(MODE_SLEEP), 32'(mode_q));
      node.pattern(30);
      @(negedge clock);
      check("mode", 32'(MODE_STANDBY), 32'(mode_q));
      check("interrupt", 32'h0, 32'(irq_n));
      check("wake request", 32'h0, 32'(wkrq_n));
      rd(16'(STAT_ADDR), d);
      check("bus wake flag", 32'h1, bit_of(d, STAT_BUS_WAKE_BIT));
      check("sleep fault flag", 32'h1, bit_of(d, STAT_SLEEP_FAULT_BIT));
      node.hold(1'b1, 30);
      @(negedge clock);
      check("internal receive", 32'h0, 32'(rxi));
      node.hold(1'b0, 30);
      @(negedge clock);
      check("internal receive", 32'h1, 32'(rxi));
      @(posedge clock);
      uv <= 1'b1;
      repeat (4) @(posedge clock);
      uv <= 1'b0;
      node.hold(1'b1, 30);
      @(negedge clock);
      check("internal receive", 32'h1, 32'(rxi));
      node.hold(1'b0, 30);
      $display("bus wake test done");
      wait_mode(MODE_SLEEP, 250);
      @(posedge clock);
      wake_pin <= 1'b0;
      repeat (200) @(posedge clock);
      wake_pin <= 1'b1;
      repeat (1100) @(posedge clock);
      check("mode", 32'(MODE_SLEEP), 32'(mode_q));
      wake_pin <= 1'b0;
      repeat (900) @(posedge clock);
      check("mode", 32'(MODE_SLEEP), 32'(mode_q));
      wait_mode(MODE_STANDBY, 300);
      rd(16'(STAT_ADDR), d);
      check("local wake flag", 32'h1, bit_of(d, STAT_LOCAL_WAKE_BIT));
      wait_mode(MODE_SLEEP, 250);
      @(posedge clock);
      wake_pin <= 1'b1;
      wait_mode(MODE_STANDBY, 1300);
      $display("local wake test done");
      wr(16'(CTRL_ADDR), 32'h0000_0014);
      wait_mode(MODE_NORMAL, 10);
      @(posedge clock);
      wake_pin <= 1'b0;
      repeat (1300) @(posedge clock);
      check("mode", 32'(MODE_NORMAL), 32'(mode_q));
      $display("normal mode test done");
      for (int i = 0; i < 16; i++) begin
         cfg = (32'(i[1]) << CFG_TEST_EN_BIT) | (32'(i[0]) << CFG_TEST_MAP_BIT);
         wr(16'(CFG_ADDR), cfg);
         rd(16'(CFG_ADDR), d);
         check("config", cfg, d);
         @(posedge clock);
         {ctx, trx, ten, cin_n, gin} <= 5'($urandom);
         repeat (4) @(posedge clock);
         @(negedge clock);
         check("pin two", 32'(exp_pin2(cfg)), 32'(pin2));
         check("io pin out", 32'h0, 32'(gout));
         if (cfg[21]) begin
            check("interrupt", 32'(!ten), 32'(irq_n));
            check("remapped in", 32'(gin), 32'(cfg[0] ? crx : txi));
         end else begin
            check("transmit in", 32'(ctx), 32'(txi));
         end
      end
      $display("test mode test done");
      wr(16'(CFG_ADDR), 32'h0000_2000);
      wait_mode(MODE_SLEEP, 250);
      wr(16'(CFG_ADDR), 32'h0000_0002);
      @(posedge clock);
      ciw <= 1'b1;
      @(posedge clock);
      ciw <= 1'b0;
      wait_mode(MODE_STANDBY, 5);
      check("interrupt", 32'h0, 32'(irq_n));
      repeat (300) @(posedge clock);
      check("mode", 32'(MODE_STANDBY), 32'(mode_q));
      wr(16'(CFG_ADDR), 32'h0000_2002);
      wait_mode(MODE_SLEEP, 10);
      $display("failsafe test done");
      report_and_stop();
   end
endmodule // test_bus_wake_and_failsafe_control
